//--- dv/fsp_cpu_model.sv
`default_nettype none
module fsp_cpu_model
(
  input wire logic aclk,
  input wire logic cpu_halt,
  input wire logic [7:0] lpm_data,
  input wire logic lpm_valid,
  input wire logic eeprom_write_busy_flag,
  input wire logic [14:0] flash_rd_addr,
  output logic spm_strobe,
  output logic lpm_strobe,
  output logic [15:0] flash_pointer,
  output logic [15:0] spm_word,
  output logic [15:0] flash_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////
  // flash array stand-in: the pattern differs in both bytes, so a swapped byte shows
  assign flash_rd_data = {flash_rd_addr[7:0] ^ 8'h5a, flash_rd_addr[7:0]};
  initial
  begin
    spm_strobe = 1'b0;
    lpm_strobe = 1'b0;
    flash_pointer = 16'h0000;
    spm_word = 16'h0000;
  end
  ////////////////////////////////////////////////////////////
  // a halted core issues nothing; eeprom must be idle before a store
  task automatic spm(input logic [15:0] p, input logic [15:0] w);
    while (cpu_halt || eeprom_write_busy_flag) @(posedge aclk);
    flash_pointer <= p;
    spm_word <= w;
    spm_strobe <= 1'b1;
    @(posedge aclk);
    spm_strobe <= 1'b0;
  endtask
  // returns x when no byte comes back, so a missing answer never compares equal
  task automatic lpm(input logic [15:0] p, output logic [7:0] d);
    int n;
    while (cpu_halt) @(posedge aclk);
    flash_pointer <= p;
    lpm_strobe <= 1'b1;
    @(posedge aclk);
    lpm_strobe <= 1'b0;
    for (n = 0; n < 8; n++)
    begin
      @(posedge aclk);
      if (lpm_valid)
        break;
    end
    d = (n < 8) ? lpm_data : 8'hxx;
  endtask
endmodule
`default_nettype wire

//--- dv/fsp_top_tb.sv
`default_nettype none
module fsp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fsp_pkg::*;
  // short page and op time keep the run brief
  localparam int PW = 8;
  localparam int PC = 40;
  localparam int IW = $clog2(PW);
  logic aclk, aresetn, eeprom_write_busy_flag;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic spm_strobe, lpm_strobe, lpm_valid, cpu_halt, flash_erase_strobe, flash_prog_strobe;
  logic [15:0] flash_pointer, spm_word, flash_rd_data, flash_prog_data;
  logic [7:0] lpm_data, low_fuse_programmed, high_fuse_programmed;
  logic [7:0] extended_fuse_programmed, lock_programmed;
  logic [14:0] flash_rd_addr;
  logic [14-IW:0] flash_prog_page, erase_page;
  logic [IW-1:0] flash_prog_word;
  logic [15:0] prog_mem [PW];
  int n_mismatch, checks_done, halt_run, last_run, prog_n;
  fsp_top #(.PAGE_WORDS(PW), .PROG_CYCLES(PC)) fsp_top_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .spm_strobe, .lpm_strobe,
    .flash_pointer, .spm_word, .lpm_data, .lpm_valid, .cpu_halt, .eeprom_write_busy_flag,
    .low_fuse_programmed, .high_fuse_programmed, .extended_fuse_programmed, .lock_programmed,
    .flash_rd_addr, .flash_rd_data, .flash_erase_strobe, .flash_prog_strobe, .flash_prog_page,
    .flash_prog_word, .flash_prog_data);
  fsp_cpu_model fsp_cpu_model_inst (.aclk, .cpu_halt, .lpm_data, .lpm_valid,
    .eeprom_write_busy_flag, .flash_rd_addr, .spm_strobe, .lpm_strobe, .flash_pointer,
    .spm_word, .flash_rd_data);
  always #25 aclk = ~aclk;
  ////////////////////////////////////////////////////////////
  // monitors: halt run length, erase page, streamed words
  always @(posedge aclk)
  begin
    if (cpu_halt)
      halt_run <= halt_run + 1;
    else if (halt_run != 0)
    begin
      last_run <= halt_run;
      halt_run <= 0;
    end
    if (flash_erase_strobe)
      erase_page <= flash_prog_page;
    if (flash_prog_strobe)
    begin
      prog_mem[flash_prog_word] <= flash_prog_data;
      prog_n <= prog_n + 1;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // bready and rready stay high throughout, so no strobe is ever dropped and raised at once
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (1)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    r = s_axi_bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (1)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic wc(input logic [4:0] c);
    logic [1:0] r;
    axi_wr(CTRL_ADDR, 32'(c), r);
    chk(32'(r), 32'(RESP_OKAY), "ctrl write resp");
  endtask
  task automatic rc(input logic [4:0] e, input string m);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(CTRL_ADDR, d, r);
    chk(32'(r), 32'(RESP_OKAY), "ctrl read resp");
    chk(d, 32'(e), m);
  endtask
  task automatic wait_op;
    @(posedge aclk);
    while (cpu_halt) @(posedge aclk);
    @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rc(5'h00, "ctrl after reset");
    axi_rd(8'h00, d, r);
    chk(32'(r), 32'(RESP_DECERR), "unmapped read");
    axi_wr(8'h00, 32'h0000_0009, r);
    chk(32'(r), 32'(RESP_DECERR), "unmapped write");
    rc(5'h00, "unmapped write ignored");
    // lane 0 carries the command, so a write without it must be dropped
    s_axi_wstrb <= 4'he;
    wc(CMD_LOCK);
    s_axi_wstrb <= 4'hf;
    rc(5'h00, "write without lane 0 ignored");
    wc(5'h07);
    rc(5'h00, "pattern 07 ignored");
    wc(5'h0d);
    rc(5'h00, "pattern 0d ignored");
    $display("t_regs done");
  endtask
  task automatic t_lpm_plain;
    logic [7:0] d;
    fsp_cpu_model_inst.lpm(16'h0abc, d);
    chk(32'(d), 32'h0000_005e, "plain low byte");
    fsp_cpu_model_inst.lpm(16'h0abd, d);
    chk(32'(d), 32'h0000_0004, "plain high byte");
    $display("t_lpm_plain done");
  endtask
  task automatic t_fuse;
    logic [7:0] d;
    logic [7:0] src [4];
    int i;
    src = '{low_fuse_programmed, lock_programmed, extended_fuse_programmed, high_fuse_programmed};
    for (i = 0; i < 4; i++)
    begin
      wc(CMD_LOCK);
      fsp_cpu_model_inst.lpm(16'(i), d);
      chk(32'(d), {24'h00_0000, ~src[i]}, "fuse or lock byte");
      rc(5'h00, "lock mode after read");
    end
    $display("t_fuse done");
  endtask
  task automatic t_timeout;
    logic [7:0] d;
    wc(CMD_LOCK);
    repeat (5) @(posedge aclk);
    rc(5'h00, "lock mode expired");
    fsp_cpu_model_inst.lpm(16'h0001, d);
    chk(32'(d), 32'h0000_005a, "read after expiry");
    wc(CMD_LOAD);
    repeat (5) @(posedge aclk);
    rc(5'h00, "load mode expired");
    $display("t_timeout done");
  endtask
  task automatic t_eeprom;
    logic [7:0] d;
    eeprom_write_busy_flag <= 1'b1;
    @(posedge aclk);
    wc(CMD_LOCK);
    fsp_cpu_model_inst.lpm(16'h0000, d);
    chk(32'(d), 32'h0000_0000, "fuse read blocked");
    rc(5'h00, "ctrl write blocked");
    eeprom_write_busy_flag <= 1'b0;
    // busy rises in the very cycle of the load or store, past the model's own check
    wc(CMD_LOCK);
    eeprom_write_busy_flag <= 1'b1;
    fsp_cpu_model_inst.lpm(16'h0000, d);
    chk(32'(d), 32'h0000_0000, "late busy blocks fuse read");
    eeprom_write_busy_flag <= 1'b0;
    wc(CMD_ERASE);
    eeprom_write_busy_flag <= 1'b1;
    fsp_cpu_model_inst.spm(16'h0000, 16'h0000);
    @(posedge aclk);
    chk(32'(cpu_halt), 32'h0000_0000, "late busy blocks erase");
    rc(5'h00, "store under busy clears ctrl");
    eeprom_write_busy_flag <= 1'b0;
    $display("t_eeprom done");
  endtask
  task automatic t_erase;
    wc(CMD_ERASE);
    fsp_cpu_model_inst.spm(16'h1234, 16'h0000);
    rc(CMD_ERASE, "enable held in erase");
    wait_op();
    chk(32'(last_run), 32'(PC), "erase halt length");
    chk(32'(erase_page), 32'(16'h1234 >> (IW + 1)), "erase page");
    rc(5'h00, "ctrl after erase");
    $display("t_erase done");
  endtask
  task automatic t_page;
    logic [15:0] base;
    int i;
    int p0;
    base = 16'h0250;
    wc(CMD_RWW);
    fsp_cpu_model_inst.spm(base, 16'h0000);
    // index 3 stays unloaded and must come out erased
    for (i = 0; i < PW; i++)
    begin
      if (i == 3)
        continue;
      rc(5'h00, "enable clear before command");
      wc(CMD_LOAD);
      fsp_cpu_model_inst.spm(base + 16'(2 * i), 16'hc000 + 16'(i));
    end
    p0 = prog_n;
    wc(CMD_WRITE);
    fsp_cpu_model_inst.spm(base, 16'h0000);
    wait_op();
    chk(32'(prog_n - p0), 32'(PW), "words streamed");
    chk(32'(last_run), 32'(PC), "write halt length");
    chk(32'(flash_prog_page), 32'(base >> (IW + 1)), "write page");
    for (i = 0; i < PW; i++)
      chk(32'(prog_mem[i]), (i == 3) ? 32'h0000_ffff : 32'(16'hc000 + 16'(i)), "word");
    rc(5'h00, "ctrl after write");
    $display("t_page done");
  endtask
  task automatic t_reset;
    wc(CMD_ERASE);
    fsp_cpu_model_inst.spm(16'h0400, 16'h0000);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'(cpu_halt), 32'h0000_0001, "halt through reset");
    wait_op();
    chk(32'(last_run), 32'(PC), "op survives reset");
    $display("t_reset done");
  endtask
  ////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    eeprom_write_busy_flag = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    low_fuse_programmed = 8'h12;
    lock_programmed = 8'h34;
    extended_fuse_programmed = 8'h56;
    high_fuse_programmed = 8'h78;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_lpm_plain();
    t_fuse();
    t_timeout();
    t_eeprom();
    t_erase();
    t_page();
    t_reset();
    print_verdict();
  end
  // a few hundred cycles are needed; five thousand leaves margin
  initial
  begin
    #(5000 * 50);
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire

//--- hw/fsp_buf_if.sv
`default_nettype none
interface fsp_buf_if #(parameter int IDX_W = 5);
  logic clr;
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [15:0] wr_data;
  logic [IDX_W-1:0] rd_idx;
  logic [15:0] rd_data;
  modport ctrl (output clr, output wr_en, output wr_idx, output wr_data, output rd_idx,
    input rd_data);
  modport store (input clr, input wr_en, input wr_idx, input wr_data, input rd_idx,
    output rd_data);
endinterface
`default_nettype wire

//--- hw/fsp_page_buf.sv
`default_nettype none
module fsp_page_buf #(
  parameter int WORDS = 32,
  parameter int IDX_W = 5
) (
  input wire logic aclk,
  fsp_buf_if.store bus
);
  import fsp_pkg::*;

  logic [15:0] mem [WORDS];
  logic [WORDS-1:0] filled;

  // the index must reach every word and nothing beyond
  if (WORDS < 2 || (1 << IDX_W) != WORDS)
    $error("fsp_page_buf: depth must be a power of two matching the index width");

  // words never loaded read as erased flash
  always_ff @(posedge aclk)
  begin
    if (bus.clr)
      filled <= '0;
    if (bus.wr_en)
      filled[bus.wr_idx] <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (bus.wr_en)
      mem[bus.wr_idx] <= bus.wr_data;
  end

  always_ff @(posedge aclk)
  begin
    bus.rd_data <= filled[bus.rd_idx] ? mem[bus.rd_idx] : ERASED_WORD;
  end
endmodule
`default_nettype wire

//--- hw/fsp_pkg.sv
`default_nettype none
package fsp_pkg;
  // bus geometry; the control register index is printed, byte address is four times it
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] CTRL_IDX = 8'h37;
  localparam logic [AXI_ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX[5:0], 2'b00};
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // control register fields
  localparam int EN_BIT = 0;
  localparam int ERASE_BIT = 1;
  localparam int WRITE_BIT = 2;
  localparam int LOCKRD_BIT = 3;
  localparam int RWWRE_BIT = 4;
  localparam int RWWBUSY_BIT = 6;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic RWW_BUSY_VAL = 1'b0;

  // legal command patterns in the low five bits
  localparam logic [4:0] CMD_RWW = 5'h11;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_LOAD = 5'h01;

  // windows after a control write, in clock cycles
  localparam logic [2:0] SPM_WIN = 3'h4;
  localparam logic [2:0] LPM_WIN = 3'h3;

  // pointer values selecting fuse and lock bytes
  localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
  localparam logic [15:0] PTR_LOCK = 16'h0001;
  localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
  localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
  localparam logic [7:0] UNMAPPED_BYTE = 8'hFF;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // programming time
  localparam int CLK_PERIOD_NS = 50;
  localparam int PROG_MIN_NS = 3700000;
  localparam int PROG_MAX_NS = 4500000;
  localparam int PROG_MIN_CYC = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_MAX_CYC = PROG_MAX_NS / CLK_PERIOD_NS;
  localparam int PAGE_WORDS_DEF = 32;

  typedef enum {OP_IDLE, OP_ERASE, OP_WRITE} fsp_op_t;
endpackage
`default_nettype wire

//--- hw/fsp_top.sv
// Function
// - pointer high bits page, low bits word
// - lpm reads bytes, pointer bit zero selects
// - eeprom write blocks programming and fuse reads
// - pointer 0x0001 with enables reads lock
// - enables auto-clear on read or timeout
// - enables clear means ordinary flash reads
// - pointer 0x0000 returns low fuse byte
// - pointer 0x0003 returns high fuse byte
// - pointer 0x0002 returns extended fuse byte
// - programmed bits read zero, unprogrammed one
// - reset lets running flash write finish
// - erase or write lasts 3.7 to 4.5 ms
// - rww busy bit always reads zero
// - command patterns select erase, load, write
// - cpu halted during erase and write
// - illegal low five bit patterns ignored
// - enable stays high until operation ends
`default_nettype none
module fsp_top #(
  parameter int PAGE_WORDS = fsp_pkg::PAGE_WORDS_DEF,
  parameter int PROG_CYCLES = fsp_pkg::PROG_MIN_CYC,
  localparam int IDX_W = $clog2(PAGE_WORDS),
  localparam int PAGE_W = 15 - IDX_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [fsp_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [fsp_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic spm_strobe,
  input wire logic lpm_strobe,
  input wire logic [15:0] flash_pointer,
  input wire logic [15:0] spm_word,
  output logic [7:0] lpm_data,
  output logic lpm_valid,
  output logic cpu_halt,
  input wire logic eeprom_write_busy_flag,
  input wire logic [7:0] low_fuse_programmed,
  input wire logic [7:0] high_fuse_programmed,
  input wire logic [7:0] extended_fuse_programmed,
  input wire logic [7:0] lock_programmed,
  output logic [14:0] flash_rd_addr,
  input wire logic [15:0] flash_rd_data,
  output logic flash_erase_strobe,
  output logic flash_prog_strobe,
  output logic [PAGE_W-1:0] flash_prog_page,
  output logic [IDX_W-1:0] flash_prog_word,
  output logic [15:0] flash_prog_data
);
  import fsp_pkg::*;

  localparam int CNT_W = $clog2(PROG_CYCLES + 1);

  // page streaming must finish inside the programming time
  if (PAGE_WORDS < 2 || (1 << IDX_W) != PAGE_WORDS || PROG_CYCLES < PAGE_WORDS + 1
      || PROG_CYCLES > PROG_MAX_CYC)
    $error("fsp_top: unsupported page size or programming time");

  ////////////////////////////////////////////////////////////////////////////
  logic aw_held;
  logic w_held;
  logic [AXI_ADDR_W-1:0] aw_addr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [4:0] ctrl;
  logic [2:0] win;
  fsp_op_t op_state;
  logic op_running;
  logic [CNT_W-1:0] op_cnt;
  logic [CNT_W-1:0] halt_cnt;
  logic str_act;
  logic [IDX_W-1:0] str_idx;
  logic eep_q;
  logic lpm_pend;
  logic fuse_mode;
  logic [15:0] lpm_ptr;
  logic wr_fire;
  logic wr_hit;
  logic cmd_legal;
  logic ctrl_take;
  logic spm_any;
  logic spm_go;
  logic lpm_fuse;
  logic op_done;
  logic [7:0] fuse_val;

  fsp_buf_if #(.IDX_W(IDX_W)) bus ();

  fsp_page_buf #(.WORDS(PAGE_WORDS), .IDX_W(IDX_W)) u_buf (
    .aclk(aclk),
    .bus(bus.store)
  );

  // an unknown state after power-up counts as idle
  always_comb
  begin
    case (op_state)
      OP_ERASE, OP_WRITE: op_running = 1'b1;
      default: op_running = 1'b0;
    endcase
  end

  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
  assign wr_hit = aw_addr_q == CTRL_ADDR;
  assign cmd_legal = wdata_q[4:0]
    inside {CMD_RWW, CMD_LOCK, CMD_WRITE, CMD_ERASE, CMD_LOAD};
  // a new command is dropped while the previous one or any eeprom write is in progress
  assign ctrl_take = wr_fire & wr_hit & wstrb_q[0] & cmd_legal & ~ctrl[EN_BIT]
    & ~op_running & ~eeprom_write_busy_flag;
  assign spm_any = spm_strobe & ctrl[EN_BIT] & ~op_running;
  assign spm_go = spm_any & ~ctrl[LOCKRD_BIT] & ~eeprom_write_busy_flag;
  assign lpm_fuse = lpm_strobe & ctrl[EN_BIT] & ctrl[LOCKRD_BIT] & ~op_running
    & ~eeprom_write_busy_flag;
  assign op_done = op_running && op_cnt == '0;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // axi4-lite read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= (s_axi_araddr == CTRL_ADDR) ? RESP_OKAY : RESP_DECERR;
      s_axi_rdata <= '0;
      if (s_axi_araddr == CTRL_ADDR)
        s_axi_rdata <= {24'h00_0000, 1'b0, RWW_BUSY_VAL, 1'b0, ctrl};
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control bits and their auto-clear windows
  always_ff @(posedge aclk)
  begin
    if (!aresetn && !op_running)
    begin
      ctrl <= CTRL_RESET;
      win <= '0;
    end
    else if (op_running)
    begin
      if (op_done)
        ctrl <= CTRL_RESET;
    end
    else if (ctrl_take)
    begin
      ctrl <= wdata_q[4:0];
      win <= wdata_q[LOCKRD_BIT] ? LPM_WIN : SPM_WIN;
    end
    else if (ctrl[EN_BIT])
    begin
      if (spm_go && (ctrl == CMD_ERASE || ctrl == CMD_WRITE))
        win <= '0;
      else if (spm_any || lpm_fuse || win == 3'h1)
        ctrl <= CTRL_RESET;
      else
        win <= win - 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // erase and write timing; a reset does not cut a running operation short
  always_ff @(posedge aclk)
  begin
    if (!aresetn && !op_running)
    begin
      op_state <= OP_IDLE;
      op_cnt <= '0;
      cpu_halt <= 1'b0;
      flash_erase_strobe <= 1'b0;
      flash_prog_page <= '0;
    end
    else
    begin
      flash_erase_strobe <= 1'b0;
      case (op_state)
        OP_IDLE:
        begin
          if (spm_go && (ctrl == CMD_ERASE || ctrl == CMD_WRITE))
          begin
            op_state <= (ctrl == CMD_ERASE) ? OP_ERASE : OP_WRITE;
            op_cnt <= CNT_W'(PROG_CYCLES - 1);
            cpu_halt <= 1'b1;
            flash_erase_strobe <= ctrl == CMD_ERASE;
            flash_prog_page <= flash_pointer[15:IDX_W+1];
          end
        end
        OP_ERASE, OP_WRITE:
        begin
          if (op_cnt == '0)
          begin
            op_state <= OP_IDLE;
            cpu_halt <= 1'b0;
          end
          else
            op_cnt <= op_cnt - CNT_W'(1);
        end
        default: op_state <= OP_IDLE;
      endcase
    end
  end

  // page buffer streams to flash one word a cycle at the start of a write
  always_ff @(posedge aclk)
  begin
    if (!aresetn && !op_running)
    begin
      str_act <= 1'b0;
      str_idx <= '0;
      flash_prog_strobe <= 1'b0;
      flash_prog_word <= '0;
    end
    else
    begin
      flash_prog_strobe <= str_act;
      flash_prog_word <= str_idx;
      if (op_state == OP_IDLE && spm_go && ctrl == CMD_WRITE)
      begin
        str_act <= 1'b1;
        str_idx <= '0;
      end
      else if (str_act)
      begin
        str_act <= str_idx != IDX_W'(PAGE_WORDS - 1);
        str_idx <= str_idx + IDX_W'(1);
      end
    end
  end
  assign flash_prog_data = bus.rd_data;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      eep_q <= 1'b0;
    else
      eep_q <= eeprom_write_busy_flag;
  end

  // an eeprom write during page loading loses the loaded data
  assign bus.clr = (!aresetn && !op_running) || (spm_go && ctrl == CMD_RWW)
    || (op_done && op_state == OP_WRITE) || (eeprom_write_busy_flag && !eep_q);
  assign bus.wr_en = spm_go && ctrl == CMD_LOAD;
  assign bus.wr_idx = flash_pointer[IDX_W:1];
  assign bus.wr_data = spm_word;
  assign bus.rd_idx = str_idx;

  ////////////////////////////////////////////////////////////////////////////
  // program memory byte reads, or fuse and lock bytes in lock-read mode
  always_comb
  begin
    case (lpm_ptr)
      PTR_LOCK: fuse_val = ~lock_programmed;
      PTR_FUSE_LOW: fuse_val = ~low_fuse_programmed;
      PTR_FUSE_HIGH: fuse_val = ~high_fuse_programmed;
      PTR_FUSE_EXT: fuse_val = ~extended_fuse_programmed;
      default: fuse_val = UNMAPPED_BYTE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lpm_pend <= 1'b0;
      lpm_valid <= 1'b0;
      lpm_data <= '0;
      lpm_ptr <= '0;
      fuse_mode <= 1'b0;
    end
    else
    begin
      lpm_pend <= lpm_strobe & ~op_running;
      lpm_valid <= lpm_pend;
      if (lpm_strobe)
      begin
        lpm_ptr <= flash_pointer;
        fuse_mode <= lpm_fuse;
      end
      if (lpm_pend)
        lpm_data <= fuse_mode ? fuse_val
          : (lpm_ptr[0] ? flash_rd_data[15:8] : flash_rd_data[7:0]);
    end
  end
  assign flash_rd_addr = lpm_ptr[15:1];

  ////////////////////////////////////////////////////////////////////////////
  // helper counter: cycles the cpu has been held
  always_ff @(posedge aclk)
  begin
    if (!cpu_halt)
      halt_cnt <= '0;
    else
      halt_cnt <= halt_cnt + CNT_W'(1);
  end

  property p_halt_len;
    @(posedge aclk) disable iff (!aresetn) $fell(cpu_halt) |-> halt_cnt == CNT_W'(PROG_CYCLES);
  endproperty
  a_halt_len: assert property (p_halt_len) else $error("operation length wrong");

  property p_halt_start;
    @(posedge aclk) disable iff (!aresetn)
      $rose(op_running) |-> cpu_halt && flash_prog_page == $past(flash_pointer[15:IDX_W+1]);
  endproperty
  a_halt_start: assert property (p_halt_start) else $error("cpu not halted at start");

  property p_en_held;
    @(posedge aclk) disable iff (!aresetn)
      $fell(op_running) |-> !ctrl[EN_BIT] && $past(ctrl[EN_BIT]);
  endproperty
  a_en_held: assert property (p_en_held) else $error("enable not held through operation");

  property p_spm_win;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_take && !wdata_q[LOCKRD_BIT]) ##1 (!spm_strobe)[*4] |=> !ctrl[EN_BIT];
  endproperty
  a_spm_win: assert property (p_spm_win) else $error("store window not closed");

  property p_lpm_win;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_take && wdata_q[LOCKRD_BIT]) ##1 (!lpm_strobe && !spm_strobe)[*3] |=> !ctrl[EN_BIT];
  endproperty
  a_lpm_win: assert property (p_lpm_win) else $error("lock window not closed");

  property p_fuse_low;
    @(posedge aclk) disable iff (!aresetn)
      lpm_fuse && flash_pointer == PTR_FUSE_LOW
      |-> ##2 lpm_valid && lpm_data == ~low_fuse_programmed;
  endproperty
  a_fuse_low: assert property (p_fuse_low) else $error("low fuse byte wrong");

  property p_fuse_high;
    @(posedge aclk) disable iff (!aresetn)
      lpm_fuse && flash_pointer == PTR_FUSE_HIGH |-> ##2 lpm_data == ~high_fuse_programmed;
  endproperty
  a_fuse_high: assert property (p_fuse_high) else $error("high fuse byte wrong");

  property p_byte_read;
    @(posedge aclk) disable iff (!aresetn)
      lpm_pend && !fuse_mode && lpm_ptr[0] |=> lpm_valid && lpm_data == $past(flash_rd_data[15:8]);
  endproperty
  a_byte_read: assert property (p_byte_read) else $error("odd byte not selected");

  property p_illegal;
    @(posedge aclk) disable iff (!aresetn)
      wr_fire && wr_hit && !cmd_legal && !ctrl[EN_BIT] && !op_running |=> ctrl == CTRL_RESET;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal command taken");

  property p_eeprom_block;
    @(posedge aclk) disable iff (!aresetn)
      spm_strobe && eeprom_write_busy_flag |=> !$rose(op_running) && !$rose(cpu_halt);
  endproperty
  a_eeprom_block: assert property (p_eeprom_block) else $error("store during eeprom write");

  property p_reset_keeps_op;
    @(posedge aclk) op_running && op_cnt != '0 |=> op_running;
  endproperty
  a_reset_keeps_op: assert property (p_reset_keeps_op) else $error("operation aborted");
endmodule
`default_nettype wire
